// ### verilog/iodg_map.vh
// Constants for the I/O address decode glue.
// Assumes inclusion by iodg_top.v and iodg_sel_decoder.v only.
`ifndef IODG_MAP_VH
`define IODG_MAP_VH

// ==========================================
// Address fields
`define IODG_IO_SPACE_BITS   16
`define IODG_SEL_LSB         2
`define IODG_SEL_MSB         4
`define IODG_BLK_LSB         5
`define IODG_BLK_MSB         7
`define IODG_BLK_MATCH       3'h7
`define IODG_NUM_SEL         8

// ==========================================
// Cycle status codes {mio, dc, wr}
`define IODG_ST_IO_READ      3'h2
`define IODG_ST_IO_WRITE     3'h3

// ==========================================
// Recovery and timeout timing
`define IODG_RECOVERY_HOLD_NS        200
`define IODG_CLK_NS          100
`define IODG_RECOVERY_HOLD_CYC       ((`IODG_RECOVERY_HOLD_NS + `IODG_CLK_NS - 1) / `IODG_CLK_NS)
`define IODG_RECOVERY_HOLD_W         4
`define IODG_TIMEOUT_CYC     64
`define IODG_TIMEOUT_W       7

`endif

// ### verilog/iodg_sel_decoder.v
// Three-to-eight select decoder with three gate enables.
// Assumes a purely combinational use; outputs are registered by the parent.
`timescale 1ns/10ps
`default_nettype none
`include "iodg_map.vh"

module iodg_sel_decoder (
	input  wire       i_gate_low_a_n, // Active-low enable
	input  wire       i_gate_low_b_n, // Active-low enable
	input  wire       i_gate_high,    // Active-high enable
	input  wire [2:0] i_sel,          // Binary select
	output wire [7:0] o_sel_n         // One-hot low selects
);
	wire gate_all;

	assign gate_all = ~i_gate_low_a_n & ~i_gate_low_b_n & i_gate_high;

	genvar g;
	generate
		for (g = 0; g < `IODG_NUM_SEL; g = g + 1) begin : g_out
			assign o_sel_n[g] = ~(gate_all & (i_sel == g));
		end
	endgenerate
endmodule

`default_nettype wire

// ### verilog/iodg_top.v
// I/O address decode glue: cycle latch, select decode, transceiver steering,
// I/O strobes and recovery hold.
// Assumes all inputs are synchronous to i_clk (processor local bus clock).
// Summary of operation
// - N decoded bits give 2^n block selects
// - I/O space 64K, small per-device blocks
// - All three gates asserted, else outputs high
// - Ignore A15-A8, decode A7-A2 to E0-FC
// - Latch start strobe, latched value gates decoder
// - High gate needs A7-A5 high plus latch
// - Completion, reset or timeout ends select
// - Decoder outputs used without address latch
// - Direction is latched write-or-read status
// - Low-true enable from byte lanes
// - Hold recovery until read data floats
// - I/O valid registered edge after start
// - Read strobe in T2 unless recovery holds
// - Read strobe ends at completion
`timescale 1ns/10ps
`default_nettype none
`include "iodg_map.vh"

module iodg_top (
	input  wire        i_clk,                  // Processor clock
	input  wire        i_srst,                 // Sync reset, active high
	input  wire        i_cycle_start_strobe_n, // Cycle start, low
	input  wire        i_mem_io_n,             // High memory, low I/O
	input  wire        i_data_ctrl_n,          // High data, low control
	input  wire        i_wr_rd_n,              // High write, low read
	input  wire [15:0] i_addr,                 // I/O address
	input  wire [3:0]  i_byte_lane_enables_n,  // Byte lanes, low
	input  wire        i_rdy_n,                // Cycle complete, low
	output reg  [7:0]  o_sel_n,                // Peripheral selects, low
	output reg         o_io_cycle_valid,       // I/O cycle pending
	output reg         o_io_rd_strobe_n,       // I/O read strobe, low
	output reg         o_io_wr_strobe_n,       // I/O write strobe, low
	output reg         o_recovery_hold,        // Recovery in progress
	output reg         o_xcvr_direction,       // 1 toward peripherals
	output reg         o_xcvr_enable_n,        // Transceiver enable, low
	output reg         o_timeout               // Cycle timed out
);
	// ==========================================
	// Cycle latch
	reg                      start_latched;
	reg                      cyc_is_write;
	reg [3:0]                lanes_n;
	reg [`IODG_TIMEOUT_W-1:0] tmo_cnt;
	reg [`IODG_RECOVERY_HOLD_W-1:0]   rec_cnt;
	reg                      rdy_prev_n;

	wire       start_now;
	wire       is_io_status;
	wire       blk_hit;
	wire       gate_high;
	wire       cyc_end;
	wire       tmo_hit;
	wire [7:0] dec_sel_n;
	wire       rd_end;
	wire [31:0] recovery_hold_load;

	// Recovery length cut to the counter width on purpose
	assign recovery_hold_load = `IODG_RECOVERY_HOLD_CYC;

	assign start_now    = ~i_cycle_start_strobe_n;
	assign is_io_status = ~i_mem_io_n & i_data_ctrl_n;
	// A15-A8 ignored; only the block field matters here
	assign blk_hit = (i_addr[`IODG_BLK_MSB:`IODG_BLK_LSB] == `IODG_BLK_MATCH);
	assign tmo_hit = (tmo_cnt == `IODG_TIMEOUT_CYC);
	assign cyc_end = ~i_rdy_n | tmo_hit;
	// High gate ends on completion or timeout
	assign gate_high = blk_hit & start_latched & ~cyc_end;
	assign rd_end = ~o_io_rd_strobe_n & cyc_end;

	iodg_sel_decoder u_dec (
		.i_gate_low_a_n (i_mem_io_n),
		.i_gate_low_b_n (~i_data_ctrl_n),
		.i_gate_high    (gate_high),
		.i_sel          (i_addr[`IODG_SEL_MSB:`IODG_SEL_LSB]),
		.o_sel_n        (dec_sel_n)
	);

	always @(posedge i_clk) begin
		if (i_srst) begin
			start_latched <= 1'b0;
			cyc_is_write  <= 1'b0;
			lanes_n       <= 4'hf;
			tmo_cnt       <= {`IODG_TIMEOUT_W{1'b0}};
		end else begin
			if (start_now & is_io_status) begin
				start_latched <= 1'b1;
				cyc_is_write  <= i_wr_rd_n;
				lanes_n       <= i_byte_lane_enables_n;
				tmo_cnt       <= {`IODG_TIMEOUT_W{1'b0}};
			end else if (start_latched & cyc_end) begin
				start_latched <= 1'b0;
			end else if (start_latched) begin
				tmo_cnt <= tmo_cnt + 1'b1;
			end
		end
	end

	// ==========================================
	// Outputs
	always @(posedge i_clk) begin
		if (i_srst) begin
			o_sel_n          <= 8'hff;
			o_io_cycle_valid <= 1'b0;
			o_io_rd_strobe_n <= 1'b1;
			o_io_wr_strobe_n <= 1'b1;
			o_xcvr_direction <= 1'b0;
			o_xcvr_enable_n  <= 1'b1;
			o_timeout        <= 1'b0;
		end else begin
			// Selects go straight out, no address latch stage
			o_sel_n   <= dec_sel_n;
			o_timeout <= start_latched & tmo_hit;
			if (start_now & is_io_status)
				o_io_cycle_valid <= 1'b1;
			else if (cyc_end)
				o_io_cycle_valid <= 1'b0;
			if (start_now & is_io_status)
				o_xcvr_direction <= i_wr_rd_n;
			// Enable only with a lane active during the cycle
			o_xcvr_enable_n <= ~(start_latched & ~cyc_end & ~(&lanes_n));
			// Read strobe waits in T2 for recovery to clear
			if (cyc_end)
				o_io_rd_strobe_n <= 1'b1;
			else if (o_io_cycle_valid & ~cyc_is_write & ~o_recovery_hold)
				o_io_rd_strobe_n <= 1'b0;
			if (cyc_end)
				o_io_wr_strobe_n <= 1'b1;
			else if (o_io_cycle_valid & cyc_is_write & ~o_recovery_hold)
				o_io_wr_strobe_n <= 1'b0;
		end
	end

	// ==========================================
	// Recovery hold after a read ends
	always @(posedge i_clk) begin
		if (i_srst) begin
			o_recovery_hold <= 1'b0;
			rec_cnt         <= {`IODG_RECOVERY_HOLD_W{1'b0}};
			rdy_prev_n      <= 1'b1;
		end else begin
			rdy_prev_n <= i_rdy_n;
			if (rd_end) begin
				// Peripheral lets go at strobe rise; bus floats later
				o_recovery_hold <= 1'b1;
				rec_cnt         <= recovery_hold_load[`IODG_RECOVERY_HOLD_W-1:0];
			end else if (rec_cnt > 1) begin
				rec_cnt <= rec_cnt - 1'b1;
			end else begin
				rec_cnt         <= {`IODG_RECOVERY_HOLD_W{1'b0}};
				o_recovery_hold <= 1'b0;
			end
		end
	end
endmodule

`default_nettype wire

// ### bench/iodg_top_sva.sv
// Port checker for the I/O decode glue.
// Assumes a bind to iodg_top; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module iodg_sva_chk (
	input wire logic        i_clk, i_srst, i_cycle_start_strobe_n, i_mem_io_n,
	input wire logic        i_data_ctrl_n, i_wr_rd_n, i_rdy_n,
	input wire logic [15:0] i_addr,
	input wire logic [3:0]  i_byte_lane_enables_n,
	input wire logic [7:0]  o_sel_n,
	input wire logic        o_io_cycle_valid, o_io_rd_strobe_n, o_io_wr_strobe_n,
	input wire logic        o_recovery_hold, o_xcvr_direction, o_xcvr_enable_n
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	wire io_go = !i_cycle_start_strobe_n && !i_mem_io_n && i_data_ctrl_n;
	valid_start_a: assert property (io_go |=> o_io_cycle_valid)
		else $error("no valid");
	sel_decode_a: assert property (o_sel_n != 8'hff |-> i_addr[7:5] == 3'h7
		&& o_sel_n == ~(8'h1 << i_addr[4:2])) else $error("bad select");
	sel_gated_a: assert property (o_sel_n != 8'hff |-> $past(o_io_cycle_valid))
		else $error("select ungated");
	end_on_rdy_a: assert property (!i_rdy_n && o_io_cycle_valid |=> o_sel_n == 8'hff
		&& !o_io_cycle_valid && o_io_rd_strobe_n) else $error("no end");
	hold_blocks_a: assert property (o_recovery_hold |-> o_io_rd_strobe_n)
		else $error("strobe in hold");
	recovery_hold_len_a: assert property ($rose(o_io_rd_strobe_n) |-> o_recovery_hold [*2] ##1 !o_recovery_hold)
		else $error("bad hold");
	dir_latch_a: assert property (io_go |=> o_xcvr_direction == $past(i_wr_rd_n))
		else $error("bad dir");
	lanes_en_a: assert property (!o_xcvr_enable_n |-> i_byte_lane_enables_n != 4'hf)
		else $error("bad enable");
	rd_only_a: assert property (!o_io_rd_strobe_n |-> o_io_cycle_valid && !o_xcvr_direction)
		else $error("bad read");
	rst_clear_a: assert property (disable iff (1'b0) i_srst |=> o_sel_n == 8'hff
		&& o_xcvr_enable_n && !o_recovery_hold) else $error("bad reset");
	cover property (!o_io_rd_strobe_n);
	cover property (!o_io_wr_strobe_n && !o_xcvr_enable_n);
	cover property ($fell(o_recovery_hold));
endmodule
bind iodg_top iodg_sva_chk u_iodg_sva_chk (.i_clk, .i_srst, .i_cycle_start_strobe_n,
	.i_mem_io_n, .i_data_ctrl_n, .i_wr_rd_n, .i_rdy_n, .i_addr, .i_byte_lane_enables_n,
	.o_sel_n, .o_io_cycle_valid, .o_io_rd_strobe_n, .o_io_wr_strobe_n, .o_recovery_hold,
	.o_xcvr_direction, .o_xcvr_enable_n);
`default_nettype wire

// ### bench/iodg_periph_model.sv
// Peripheral completion model.
// Assumes the glue's cycle-valid flag on the same clock.
`timescale 1ns/10ps
`default_nettype none
module iodg_periph_model (
	input  wire logic i_clk, i_valid, i_slow, i_mute, // Cycle and pace
	output var logic  o_rdy_n                         // Completion, low
);
	logic [2:0] cnt;
	always @(posedge i_clk) begin
		o_rdy_n <= 1'b1;
		cnt <= (!i_valid || !o_rdy_n) ? 3'h0 : cnt + 3'h1;
		// One completion per cycle
		// Cycles strictly one at a time, in issue order
		// Each access completes before the next starts
		// Data released at strobe rise; no snoop traffic here
		if (i_valid && o_rdy_n && !i_mute && cnt == (i_slow ? 3'h5 : 3'h1))
			o_rdy_n <= 1'b0;
	end
endmodule
`default_nettype wire

// ### bench/iodg_top_tb.sv
// Bench for the I/O decode glue.
// Assumes the glue, checker and peripheral model.
`timescale 1ns/10ps
`default_nettype none
module iodg_top_tb;
	logic        i_clk = 0, i_srst = 1, i_cycle_start_strobe_n = 1, i_mem_io_n = 0;
	logic        i_data_ctrl_n = 1, i_wr_rd_n = 0, i_rdy_n, slow = 0, mute = 0;
	logic [15:0] i_addr = 16'h0;
	logic [3:0]  i_byte_lane_enables_n = 4'h0;
	logic [7:0]  o_sel_n;
	logic        o_io_cycle_valid, o_io_rd_strobe_n, o_io_wr_strobe_n, o_recovery_hold;
	logic        o_xcvr_direction, o_xcvr_enable_n, o_timeout;
	integer      n_mismatch = 0, tests_run = 0, k, i;
	always #50 i_clk = ~i_clk;
	iodg_top u_iodg_top (.i_clk, .i_srst, .i_cycle_start_strobe_n, .i_mem_io_n,
		.i_data_ctrl_n, .i_wr_rd_n, .i_addr, .i_byte_lane_enables_n, .i_rdy_n, .o_sel_n,
		.o_io_cycle_valid, .o_io_rd_strobe_n, .o_io_wr_strobe_n, .o_recovery_hold,
		.o_xcvr_direction, .o_xcvr_enable_n, .o_timeout);
	iodg_periph_model u_iodg_periph_model (.i_clk, .i_valid(o_io_cycle_valid),
		.i_slow(slow), .i_mute(mute), .o_rdy_n(i_rdy_n));
	task chk(input string nm, input [7:0] s, e);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %s exp %h seen %h", nm, e, s);
		end
	endtask
	task complete_run;
		$display("mismatches %0d checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task cyc(input [15:0] a, input m, d, w, input [3:0] be);
		logic io, hit;
		io = !m && d;
		hit = io && a[7:5] == 3'h7;
		i_cycle_start_strobe_n <= 1'b0;
		{i_addr, i_mem_io_n, i_data_ctrl_n, i_wr_rd_n, i_byte_lane_enables_n} <= {a, m, d, w, be};
		@(posedge i_clk);
		i_cycle_start_strobe_n <= 1'b1;
		@(posedge i_clk);
		#1 chk("valid", o_io_cycle_valid, io);
		@(posedge i_clk);
		#1 chk("sel", o_sel_n, hit ? ~(8'h1 << a[4:2]) : 8'hff);
		chk("rd", {o_io_rd_strobe_n, o_io_wr_strobe_n}, {!(io && !w), !(io && w)});
		if (io) chk("dir", o_xcvr_direction, w);
		if (hit || !io) chk("en", o_xcvr_enable_n, !(hit && be != 4'hf));
		k = 0;
		do begin
			@(posedge i_clk);
			k++;
		end while (io && i_rdy_n && !o_timeout && k < 90);
		if (k >= 90) begin
			n_mismatch++;
			complete_run;
		end
		if (io) chk("tmo", o_timeout, mute);
	endtask
	task t_reset;
		i_srst <= 1'b1;
		repeat (4) @(posedge i_clk);
		i_srst <= 1'b0;
		#1 chk("rst", {o_sel_n[0], o_io_cycle_valid, o_io_rd_strobe_n, o_io_wr_strobe_n,
			o_recovery_hold, o_xcvr_direction, o_xcvr_enable_n, o_timeout}, 8'hb2);
		@(posedge i_clk);
	endtask
	task t_sweep;
		for (i = 0; i < 8; i++) begin
			slow <= i[0];
			cyc({8'h11 * i[7:0], 3'h7, i[2:0], i[1:0]}, 1'b0, 1'b1, i[1], ~(4'h1 << i[1:0]));
		end
	endtask
	task t_refuse;
		cyc(16'h00c4, 1'b0, 1'b1, 1'b0, 4'h0);
		cyc(16'h00e4, 1'b1, 1'b1, 1'b0, 4'h0);
		cyc(16'h00e4, 1'b0, 1'b0, 1'b0, 4'h0);
		cyc(16'h00e8, 1'b0, 1'b1, 1'b1, 4'hf);
	endtask
	task t_timeout;
		mute <= 1'b1;
		cyc(16'h00fc, 1'b0, 1'b1, 1'b1, 4'h0);
		mute <= 1'b0;
	endtask
	initial begin
		t_reset;
		t_sweep;
		t_refuse;
		t_timeout;
		t_reset;
		complete_run;
	end
endmodule
`default_nettype wire
